// ---- hdl/status_byte_service.sv ----
// status byte, service request and individual status logic with its command port
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - bit 6 is the OR of every other status bit ANDed with its service mask bit
// - service mask bit 6 takes no part in the master bit or requests
// - a 0 to 1 change of an enabled status bit raises a service request
// - bit 1 follows the device status register sum bit
// - bit 2 shows a non-empty error queue; each new entry requests service when enabled
// - bit 3 follows the questionable register sum bit
// - bit 4 shows a response message waiting in the output queue
// - bit 5 follows the standard event register sum through its mask
// - bit 7 follows the operation register sum bit
// - status byte query and serial poll both return the current status byte
// - controller writes and reads back the service request mask
// - individual flag is OR of status bits ANDed with parallel mask, bit 6 included
// - parallel poll and individual status query both report the individual flag
// - controller writes and reads back the parallel poll mask
// - each lower sum bit is the OR of event bits ANDed with enable bits
// - reading a lower event part clears it, which may drop its summary bit
module status_byte_service #(
    parameter int SCPI_WIDTH = status_pkg::SCPI_W
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [SCPI_WIDTH-1:0] deviceCondition,
    input wire logic [SCPI_WIDTH-1:0] questCondition,
    input wire logic [SCPI_WIDTH-1:0] operCondition,
    input wire logic [status_pkg::BYTE_W-1:0] stdEventSet,
    input wire logic errorQueueNotEmpty,
    input wire logic errorQueuePush,
    input wire logic messageWaiting,
    input wire logic cmdValid,
    input wire logic [3:0] cmdCode,
    input wire logic [status_pkg::DATA_W-1:0] cmdData,
    output logic respValid,
    output logic [status_pkg::DATA_W-1:0] respData,
    output logic serviceRequest,
    output logic individualStatusFlag,
    output logic [status_pkg::BYTE_W-1:0] statusSummaryByte
);

    status_pkg::command_e cmd;
    logic [7:0] serviceMask_q;
    logic [7:0] parallelMask_q;
    logic [SCPI_WIDTH-1:0] devPrev_q;
    logic [SCPI_WIDTH-1:0] questPrev_q;
    logic [SCPI_WIDTH-1:0] operPrev_q;
    logic [7:0] enabledPrev_q;
    logic [7:0] stb_q;
    logic ist_q;
    logic srq_q;
    logic srq_d;
    logic respValid_q;
    logic [15:0] respData_q;
    logic [15:0] respData_d;
    logic [7:0] sourceBits;
    logic [7:0] stbRaw;
    logic [7:0] srqEnabled;
    logic [7:0] risingEnabled;
    logic masterBit;
    logic istNow;
    logic devSum;
    logic questSum;
    logic operSum;
    logic stdSum;
    logic [SCPI_WIDTH-1:0] devEvent;
    logic [SCPI_WIDTH-1:0] questEvent;
    logic [SCPI_WIDTH-1:0] operEvent;
    logic [7:0] stdEvent;
    logic [SCPI_WIDTH-1:0] devEnable;
    logic [SCPI_WIDTH-1:0] questEnable;
    logic [SCPI_WIDTH-1:0] operEnable;
    logic [7:0] stdEnable;
    logic [SCPI_WIDTH-1:0] usedMask;

    assign cmd = status_pkg::command_e'(cmdCode);
    assign usedMask = SCPI_WIDTH'(status_pkg::SCPI_USED_MASK);

    // condition inputs come from logic on this clock; events latch on 0 to 1 only
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            devPrev_q <= '0;
            questPrev_q <= '0;
            operPrev_q <= '0;
        end
        else
        begin
            devPrev_q <= deviceCondition;
            questPrev_q <= questCondition;
            operPrev_q <= operCondition;
        end
    end

    status_event_register #(
        .WIDTH(SCPI_WIDTH)
    ) deviceReg (
        .clock(clock),
        .rst_b(rst_b),
        .setBits(deviceCondition & ~devPrev_q & usedMask),
        .readClear(cmdValid && cmd == status_pkg::CMD_DEVICE_EVENT_RD),
        .enableWrite(cmdValid && cmd == status_pkg::CMD_DEVICE_ENABLE_WR),
        .enableData(cmdData[SCPI_WIDTH-1:0] & usedMask),
        .eventBits(devEvent),
        .enableBits(devEnable),
        .summary(devSum)
    );

    status_event_register #(
        .WIDTH(SCPI_WIDTH)
    ) questReg (
        .clock(clock),
        .rst_b(rst_b),
        .setBits(questCondition & ~questPrev_q & usedMask),
        .readClear(cmdValid && cmd == status_pkg::CMD_QUEST_EVENT_RD),
        .enableWrite(cmdValid && cmd == status_pkg::CMD_QUEST_ENABLE_WR),
        .enableData(cmdData[SCPI_WIDTH-1:0] & usedMask),
        .eventBits(questEvent),
        .enableBits(questEnable),
        .summary(questSum)
    );

    status_event_register #(
        .WIDTH(SCPI_WIDTH)
    ) operReg (
        .clock(clock),
        .rst_b(rst_b),
        .setBits(operCondition & ~operPrev_q & usedMask),
        .readClear(cmdValid && cmd == status_pkg::CMD_OPER_EVENT_RD),
        .enableWrite(cmdValid && cmd == status_pkg::CMD_OPER_ENABLE_WR),
        .enableData(cmdData[SCPI_WIDTH-1:0] & usedMask),
        .eventBits(operEvent),
        .enableBits(operEnable),
        .summary(operSum)
    );

    // standard events arrive as pulses, already edge-qualified upstream
    status_event_register #(
        .WIDTH(status_pkg::BYTE_W)
    ) stdReg (
        .clock(clock),
        .rst_b(rst_b),
        .setBits(stdEventSet),
        .readClear(cmdValid && cmd == status_pkg::CMD_STD_EVENT_RD),
        .enableWrite(cmdValid && cmd == status_pkg::CMD_STD_ENABLE_WR),
        .enableData(cmdData[status_pkg::BYTE_W-1:0]),
        .eventBits(stdEvent),
        .enableBits(stdEnable),
        .summary(stdSum)
    );

    // sources kept apart from the master bit so its sum never feeds back on itself
    always_comb
    begin
        sourceBits = '0;
        sourceBits[status_pkg::BIT_DEVICE] = devSum;
        sourceBits[status_pkg::BIT_ERRQ] = errorQueueNotEmpty;
        sourceBits[status_pkg::BIT_QUEST] = questSum;
        sourceBits[status_pkg::BIT_MSG] = messageWaiting;
        sourceBits[status_pkg::BIT_STDEV] = stdSum;
        sourceBits[status_pkg::BIT_OPER] = operSum;
    end
    assign stbRaw = sourceBits | (8'(masterBit) << status_pkg::BIT_MASTER);
    assign srqEnabled = sourceBits & serviceMask_q & status_pkg::SRQ_SOURCE_MASK;

    masked_summary #(
        .WIDTH(status_pkg::BYTE_W)
    ) masterSum (
        .bits(srqEnabled),
        .mask(status_pkg::SRQ_SOURCE_MASK),
        .summary(masterBit)
    );

    masked_summary #(
        .WIDTH(status_pkg::BYTE_W)
    ) istSum (
        .bits(stbRaw),
        .mask(parallelMask_q & status_pkg::IST_SOURCE_MASK),
        .summary(istNow)
    );

    assign risingEnabled = srqEnabled & ~enabledPrev_q;

    // request holds until a serial poll or until no enabled source stays set;
    // a new rise in the poll cycle wins so it is not lost
    always_comb
    begin
        srq_d = srq_q;
        if ((cmdValid && cmd == status_pkg::CMD_SERIAL_POLL) || !masterBit)
            srq_d = 1'b0;
        if (|risingEnabled)
            srq_d = 1'b1;
        if (errorQueuePush && serviceMask_q[status_pkg::BIT_ERRQ])
            srq_d = 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            srq_q <= 1'b0;
            enabledPrev_q <= '0;
            stb_q <= '0;
            ist_q <= 1'b0;
        end
        else
        begin
            srq_q <= srq_d;
            enabledPrev_q <= srqEnabled;
            stb_q <= stbRaw;
            ist_q <= istNow;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            serviceMask_q <= status_pkg::SERVICE_MASK_RESET;
        else if (cmdValid && cmd == status_pkg::CMD_SERVICE_MASK_WR)
            serviceMask_q <= cmdData[7:0];
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            parallelMask_q <= status_pkg::PARALLEL_MASK_RESET;
        else if (cmdValid && cmd == status_pkg::CMD_PARALLEL_MASK_WR)
            parallelMask_q <= cmdData[7:0];
    end

    // every command gets a one-cycle answer; writes answer with zero
    always_comb
    begin
        respData_d = '0;
        case (cmd)
            status_pkg::CMD_SERVICE_MASK_RD: respData_d = {8'h00, serviceMask_q};
            status_pkg::CMD_PARALLEL_MASK_RD: respData_d = {8'h00, parallelMask_q};
            status_pkg::CMD_STATUS_BYTE_QUERY: respData_d = {8'h00, stbRaw};
            status_pkg::CMD_SERIAL_POLL: respData_d = {8'h00, stbRaw};
            status_pkg::CMD_INDIVIDUAL_STATUS_QUERY: respData_d = {15'h0000, istNow};
            status_pkg::CMD_PARALLEL_POLL: respData_d = {15'h0000, istNow};
            status_pkg::CMD_DEVICE_EVENT_RD: respData_d = 16'(devEvent);
            status_pkg::CMD_QUEST_EVENT_RD: respData_d = 16'(questEvent);
            status_pkg::CMD_OPER_EVENT_RD: respData_d = 16'(operEvent);
            status_pkg::CMD_STD_EVENT_RD: respData_d = {8'h00, stdEvent};
            default: respData_d = '0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            respValid_q <= 1'b0;
            respData_q <= '0;
        end
        else
        begin
            respValid_q <= cmdValid;
            respData_q <= cmdValid ? respData_d : '0;
        end
    end

    assign respValid = respValid_q;
    assign respData = respData_q;
    assign serviceRequest = srq_q;
    assign individualStatusFlag = ist_q;
    assign statusSummaryByte = stb_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence serviceMaskWrite;
        cmdValid && cmd == status_pkg::CMD_SERVICE_MASK_WR;
    endsequence

    sequence serviceMaskRead;
        cmdValid && cmd == status_pkg::CMD_SERVICE_MASK_RD;
    endsequence

    sequence parallelMaskWrite;
        cmdValid && cmd == status_pkg::CMD_PARALLEL_MASK_WR;
    endsequence

    sequence parallelMaskRead;
        cmdValid && cmd == status_pkg::CMD_PARALLEL_MASK_RD;
    endsequence

    chk_master_bit_sum: assert property (
        statusSummaryByte[status_pkg::BIT_MASTER] ==
        |(statusSummaryByte & $past(serviceMask_q) & status_pkg::SRQ_SOURCE_MASK))
        else $error("master bit differs from masked status byte");

    chk_srq_rise: assert property (
        (|(srqEnabled & ~enabledPrev_q)) |=> serviceRequest)
        else $error("enabled rising status bit raised no request");

    chk_errq_bit: assert property (
        errorQueueNotEmpty |=> statusSummaryByte[status_pkg::BIT_ERRQ])
        else $error("error queue bit missing");

    chk_errq_push_srq: assert property (
        errorQueuePush && serviceMask_q[status_pkg::BIT_ERRQ] |=> serviceRequest)
        else $error("error entry raised no request");

    chk_message_bit: assert property (
        messageWaiting == $past(messageWaiting, 1) |-> ##1 statusSummaryByte[status_pkg::BIT_MSG] == $past(messageWaiting))
        else $error("message bit does not follow output queue");

    chk_bit0_zero: assert property (
        !statusSummaryByte[status_pkg::BIT_UNUSED] && !respData[status_pkg::BIT_UNUSED] ||
        $past(cmdValid && (cmd == status_pkg::CMD_INDIVIDUAL_STATUS_QUERY || cmd == status_pkg::CMD_PARALLEL_POLL ||
        cmd == status_pkg::CMD_SERVICE_MASK_RD || cmd == status_pkg::CMD_PARALLEL_MASK_RD ||
        cmd >= status_pkg::CMD_DEVICE_EVENT_RD)))
        else $error("status bit 0 not zero");

    chk_ist_flag: assert property (
        individualStatusFlag == |(statusSummaryByte & $past(parallelMask_q) & status_pkg::IST_SOURCE_MASK))
        else $error("individual flag differs from parallel masked byte");

    chk_service_readback: assert property (
        serviceMaskWrite ##1 serviceMaskRead |=> respValid && respData == {8'h00, $past(cmdData[7:0], 2)})
        else $error("service mask read back wrong");

    chk_parallel_readback: assert property (
        parallelMaskWrite ##1 parallelMaskRead |=> respValid && respData == {8'h00, $past(cmdData[7:0], 2)})
        else $error("parallel mask read back wrong");

    chk_poll_answer: assert property (
        cmdValid && (cmd == status_pkg::CMD_SERIAL_POLL || cmd == status_pkg::CMD_STATUS_BYTE_QUERY)
        |=> respValid && respData[7:0] == statusSummaryByte)
        else $error("poll answer differs from status byte");

    chk_event_clear: assert property (
        cmdValid && cmd == status_pkg::CMD_DEVICE_EVENT_RD && deviceCondition == devPrev_q |=> devEvent == '0)
        else $error("device event not cleared by read");

endmodule
`default_nettype wire

// ---- hdl/status_pkg.sv ----
// shared constants for the status byte and service request block
package status_pkg;

    localparam int BYTE_W = 8;
    localparam int SCPI_W = 16;
    localparam int DATA_W = 16;

    // status byte bit positions
    localparam int BIT_UNUSED = 0;
    localparam int BIT_DEVICE = 1;
    localparam int BIT_ERRQ = 2;
    localparam int BIT_QUEST = 3;
    localparam int BIT_MSG = 4;
    localparam int BIT_STDEV = 5;
    localparam int BIT_MASTER = 6;
    localparam int BIT_OPER = 7;

    // bits that may raise a service request: never the master bit nor the unused bit
    localparam logic [7:0] SRQ_SOURCE_MASK = 8'hBE;
    // bits that may take part in the individual status flag: master bit included
    localparam logic [7:0] IST_SOURCE_MASK = 8'hFE;
    // top bit of every 16-bit lower-level register always reads zero
    localparam logic [15:0] SCPI_USED_MASK = 16'h7FFF;

    localparam logic [7:0] SERVICE_MASK_RESET = 8'h00;
    localparam logic [7:0] PARALLEL_MASK_RESET = 8'h00;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] EVENT_RESET = 16'h0000;

    typedef enum logic [3:0] {
        CMD_SERVICE_MASK_WR = 4'h0,
        CMD_SERVICE_MASK_RD = 4'h1,
        CMD_PARALLEL_MASK_WR = 4'h2,
        CMD_PARALLEL_MASK_RD = 4'h3,
        CMD_STATUS_BYTE_QUERY = 4'h4,
        CMD_SERIAL_POLL = 4'h5,
        CMD_INDIVIDUAL_STATUS_QUERY = 4'h6,
        CMD_PARALLEL_POLL = 4'h7,
        CMD_DEVICE_EVENT_RD = 4'h8,
        CMD_QUEST_EVENT_RD = 4'h9,
        CMD_OPER_EVENT_RD = 4'hA,
        CMD_STD_EVENT_RD = 4'hB,
        CMD_DEVICE_ENABLE_WR = 4'hC,
        CMD_QUEST_ENABLE_WR = 4'hD,
        CMD_OPER_ENABLE_WR = 4'hE,
        CMD_STD_ENABLE_WR = 4'hF
    } command_e;

endpackage

// ---- hdl/masked_summary.sv ----
// or-reduction of a vector gated bit by bit with an enable mask
`timescale 1ns/1ns
`default_nettype none
module masked_summary #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] bits,
    input wire logic [WIDTH-1:0] mask,
    output logic summary
);

    assign summary = |(bits & mask);

endmodule
`default_nettype wire

// ---- hdl/status_event_register.sv ----
// event part with enable part and sum bit of one lower-level status register
`timescale 1ns/1ns
`default_nettype none
module status_event_register #(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] setBits,
    input wire logic readClear,
    input wire logic enableWrite,
    input wire logic [WIDTH-1:0] enableData,
    output logic [WIDTH-1:0] eventBits,
    output logic [WIDTH-1:0] enableBits,
    output logic summary
);

    logic [WIDTH-1:0] event_q;
    logic [WIDTH-1:0] event_d;
    logic [WIDTH-1:0] enable_q;

    // a set arriving with the read still lands, so no event is lost
    always_comb
    begin
        event_d = (readClear ? '0 : event_q) | setBits;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            event_q <= WIDTH'(status_pkg::EVENT_RESET);
        else
            event_q <= event_d;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            enable_q <= WIDTH'(status_pkg::ENABLE_RESET);
        else if (enableWrite)
            enable_q <= enableData;
    end

    masked_summary #(
        .WIDTH(WIDTH)
    ) sumBit (
        .bits(event_q),
        .mask(enable_q),
        .summary(summary)
    );

    assign eventBits = event_q;
    assign enableBits = enable_q;

endmodule
`default_nettype wire

// ---- verif/status_bus_controller.sv ----
// bus controller model issuing commands on the status command port
`timescale 1ns/1ns
`default_nettype none
module status_bus_controller (
    input wire logic clock,
    input wire logic respValid,
    input wire logic [status_pkg::DATA_W-1:0] respData,
    output logic cmdValid,
    output logic [3:0] cmdCode,
    output logic [status_pkg::DATA_W-1:0] cmdData
);
    // idle cycles before each command, raised to act as a slow controller
    int gapCycles = 0;

    initial
    begin
        cmdValid = 1'b0;
        cmdCode = 4'h0;
        cmdData = 16'h0000;
    end

    // always lets one edge pass first, so back-to-back calls never retime the strobe
    task automatic command(input logic [3:0] code, input logic [15:0] data, output logic [15:0] resp,
        output logic ok);
        @(negedge clock);
        repeat (gapCycles) @(negedge clock);
        cmdValid = 1'b1;
        cmdCode = code;
        cmdData = data;
        @(negedge clock);
        ok = respValid;
        resp = respData;
        cmdValid = 1'b0;
        // released lines show the inverse so stale values never pass as valid
        cmdCode = ~code;
        cmdData = ~data;
    endtask

    // a write then its read-back in consecutive cycles, strobe held high across both
    task automatic write_read(input logic [3:0] wrCode, input logic [3:0] rdCode, input logic [15:0] data,
        output logic [15:0] resp, output logic ok);
        @(negedge clock);
        repeat (gapCycles) @(negedge clock);
        cmdValid = 1'b1;
        cmdCode = wrCode;
        cmdData = data;
        @(negedge clock);
        ok = respValid && respData == 16'h0000;
        cmdCode = rdCode;
        cmdData = ~data;
        @(negedge clock);
        ok = ok && respValid;
        resp = respData;
        cmdValid = 1'b0;
        cmdCode = ~rdCode;
        cmdData = data;
    endtask
endmodule
`default_nettype wire

// ---- verif/tb_status_byte_service.sv ----
// self-checking bench for the status byte and service request block
`timescale 1ns/1ns
`default_nettype none
module tb_status_byte_service;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] deviceCondition = 16'h0000;
    logic [15:0] questCondition = 16'h0000;
    logic [15:0] operCondition = 16'h0000;
    logic [7:0] stdEventSet = 8'h00;
    logic errorQueueNotEmpty = 1'b0;
    logic errorQueuePush = 1'b0;
    logic messageWaiting = 1'b0;
    logic cmdValid;
    logic [3:0] cmdCode;
    logic [15:0] cmdData;
    logic respValid;
    logic [15:0] respData;
    logic serviceRequest;
    logic individualStatusFlag;
    logic [7:0] statusSummaryByte;
    int failCount = 0;
    int comparisons = 0;
    int cycles = 0;
    int srcBit[6] = '{1, 2, 3, 4, 5, 7};
    logic [15:0] r;
    logic [7:0] e;

    always #20 clock = ~clock;

    status_byte_service dut_u (
        .clock(clock),
        .rst_b(rst_b),
        .deviceCondition(deviceCondition),
        .questCondition(questCondition),
        .operCondition(operCondition),
        .stdEventSet(stdEventSet),
        .errorQueueNotEmpty(errorQueueNotEmpty),
        .errorQueuePush(errorQueuePush),
        .messageWaiting(messageWaiting),
        .cmdValid(cmdValid),
        .cmdCode(cmdCode),
        .cmdData(cmdData),
        .respValid(respValid),
        .respData(respData),
        .serviceRequest(serviceRequest),
        .individualStatusFlag(individualStatusFlag),
        .statusSummaryByte(statusSummaryByte)
    );

    status_bus_controller ctrl_u (
        .clock(clock),
        .respValid(respValid),
        .respData(respData),
        .cmdValid(cmdValid),
        .cmdCode(cmdCode),
        .cmdData(cmdData)
    );

    task automatic check_flag(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            failCount++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failCount++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failCount++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmd(input logic [3:0] code, input logic [15:0] data, output logic [15:0] resp);
        logic ok;
        ctrl_u.command(code, data, resp, ok);
        check_flag("respValid", 1'b1, ok);
    endtask

    task automatic write_back(input logic [3:0] wrCode, input logic [3:0] rdCode, input logic [15:0] data);
        logic [15:0] rd;
        logic ok;
        ctrl_u.write_read(wrCode, rdCode, data, rd, ok);
        check_flag("respValid", 1'b1, ok);
        check_word("maskReadback", {8'h00, data[7:0]}, rd);
    endtask

    // level inputs need one edge for the event and one for the registered byte
    task automatic settle;
        repeat (3) @(negedge clock);
    endtask

    task automatic raise(input int b);
        @(negedge clock);
        case (b)
            1: deviceCondition = 16'h0001;
            2: errorQueueNotEmpty = 1'b1;
            3: questCondition = 16'h0008;
            4: messageWaiting = 1'b1;
            5: stdEventSet = 8'h20;
            default: operCondition = 16'h0100;
        endcase
        @(negedge clock);
        stdEventSet = 8'h00;
    endtask

    // conditions fall, latched events are read back and cleared
    task automatic drop(input int b);
        logic [15:0] rd;
        logic [3:0] code;
        logic [15:0] exp;
        deviceCondition = 16'h0000;
        questCondition = 16'h0000;
        operCondition = 16'h0000;
        errorQueueNotEmpty = 1'b0;
        messageWaiting = 1'b0;
        case (b)
            1: {code, exp} = {status_pkg::CMD_DEVICE_EVENT_RD, 16'h0001};
            3: {code, exp} = {status_pkg::CMD_QUEST_EVENT_RD, 16'h0008};
            5: {code, exp} = {status_pkg::CMD_STD_EVENT_RD, 16'h0020};
            default: {code, exp} = {status_pkg::CMD_OPER_EVENT_RD, 16'h0100};
        endcase
        if (b == 1 || b == 3 || b == 5 || b == 7)
        begin
            cmd(code, 16'h0000, rd);
            check_word("eventRead", exp, rd);
        end
        settle();
        check_byte("statusSummaryByte", 8'h00, statusSummaryByte);
    endtask

    task automatic stop_test;
        $display("comparisons %0d failCount %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failCount++;
            stop_test();
        end
    end

    initial
    begin
        repeat (6) @(negedge clock);
        rst_b = 1'b1;
        @(negedge clock);
        check_byte("statusSummaryByte", 8'h00, statusSummaryByte);
        check_flag("serviceRequest", 1'b0, serviceRequest);
        cmd(status_pkg::CMD_SERVICE_MASK_RD, 16'h0000, r);
        check_word("serviceMask", {8'h00, status_pkg::SERVICE_MASK_RESET}, r);
        cmd(status_pkg::CMD_PARALLEL_MASK_RD, 16'h0000, r);
        check_word("parallelMask", {8'h00, status_pkg::PARALLEL_MASK_RESET}, r);
        cmd(status_pkg::CMD_DEVICE_ENABLE_WR, 16'h7FFF, r);
        cmd(status_pkg::CMD_QUEST_ENABLE_WR, 16'h7FFF, r);
        cmd(status_pkg::CMD_OPER_ENABLE_WR, 16'h7FFF, r);
        cmd(status_pkg::CMD_STD_ENABLE_WR, 16'h00FF, r);
        cmd(status_pkg::CMD_SERVICE_MASK_WR, 16'h00BE, r);
        cmd(status_pkg::CMD_SERVICE_MASK_RD, 16'h0000, r);
        check_word("serviceMask", 16'h00BE, r);
        ctrl_u.gapCycles = 3;
        cmd(status_pkg::CMD_PARALLEL_MASK_WR, 16'h00FE, r);
        cmd(status_pkg::CMD_PARALLEL_MASK_RD, 16'h0000, r);
        check_word("parallelMask", 16'h00FE, r);
        ctrl_u.gapCycles = 0;
        foreach (srcBit[i])
        begin
            raise(srcBit[i]);
            settle();
            e = 8'h40 | (8'h01 << srcBit[i]);
            check_byte("statusSummaryByte", e, statusSummaryByte);
            check_flag("serviceRequest", 1'b1, serviceRequest);
            check_flag("individualStatusFlag", 1'b1, individualStatusFlag);
            cmd(status_pkg::CMD_STATUS_BYTE_QUERY, 16'h0000, r);
            check_word("statusQuery", {8'h00, e}, r);
            cmd(status_pkg::CMD_SERIAL_POLL, 16'h0000, r);
            check_word("serialPoll", {8'h00, e}, r);
            check_flag("serviceRequest", 1'b0, serviceRequest);
            cmd(status_pkg::CMD_INDIVIDUAL_STATUS_QUERY, 16'h0000, r);
            check_word("individualQuery", 16'h0001, r);
            cmd(status_pkg::CMD_PARALLEL_POLL, 16'h0000, r);
            check_word("parallelPoll", 16'h0001, r);
            drop(srcBit[i]);
        end
        // mask bits 6 and 0 alone must not reach the master bit or a request
        write_back(status_pkg::CMD_SERVICE_MASK_WR, status_pkg::CMD_SERVICE_MASK_RD, 16'h0041);
        write_back(status_pkg::CMD_PARALLEL_MASK_WR, status_pkg::CMD_PARALLEL_MASK_RD, 16'h0040);
        raise(1);
        settle();
        check_byte("statusSummaryByte", 8'h02, statusSummaryByte);
        check_flag("serviceRequest", 1'b0, serviceRequest);
        check_flag("individualStatusFlag", 1'b0, individualStatusFlag);
        cmd(status_pkg::CMD_SERVICE_MASK_WR, 16'h0002, r);
        settle();
        check_byte("statusSummaryByte", 8'h42, statusSummaryByte);
        check_flag("individualStatusFlag", 1'b1, individualStatusFlag);
        cmd(status_pkg::CMD_PARALLEL_MASK_WR, 16'h0001, r);
        settle();
        check_flag("individualStatusFlag", 1'b0, individualStatusFlag);
        drop(1);
        // every new error entry requests service while the bit stays set
        cmd(status_pkg::CMD_SERVICE_MASK_WR, 16'h0004, r);
        raise(2);
        settle();
        check_flag("serviceRequest", 1'b1, serviceRequest);
        cmd(status_pkg::CMD_SERIAL_POLL, 16'h0000, r);
        check_flag("serviceRequest", 1'b0, serviceRequest);
        errorQueuePush = 1'b1;
        @(negedge clock);
        errorQueuePush = 1'b0;
        settle();
        check_flag("serviceRequest", 1'b1, serviceRequest);
        drop(2);
        check_flag("serviceRequest", 1'b0, serviceRequest);
        // a rise on a disabled bit shows in the byte but requests nothing
        cmd(status_pkg::CMD_SERVICE_MASK_WR, 16'h0000, r);
        raise(4);
        settle();
        check_byte("statusSummaryByte", 8'h10, statusSummaryByte);
        check_flag("serviceRequest", 1'b0, serviceRequest);
        drop(4);
        stop_test();
    end
endmodule
`default_nettype wire
